// ===== common/pwg_consts.svh
// Offsets, field positions, reset values and sizes of the port wake gate
`ifndef PWG_CONSTS_SVH
`define PWG_CONSTS_SVH

`define PWG_NPORTS        7
`define PWG_NPHY          5
`define PWG_IDX_W         16
`define PWG_IDX_EVENT     12'h013
`define PWG_IDX_ENABLE    12'h017
`define PWG_IDX_PENDING   12'h01b
`define PWG_IDX_BLOCK     12'h01f
`define PWG_IDX_IRQ_STAT  12'h001
`define PWG_IDX_IRQ_MASK  12'h002
`define PWG_GLOBAL_PORT   4'h0
`define PWG_BIT_MAGIC     2
`define PWG_BIT_LINK      1
`define PWG_BIT_ENERGY    0
`define PWG_BIT_TS        2
`define PWG_BIT_PHY       1
`define PWG_BIT_ACL       0
`define PWG_FIELD_RST     3'h0
`define PWG_IRQ_RST       7'h00
`define PWG_PHY_BITS      3'h7
`define PWG_MAC_BITS      3'h4
`define PWG_MAC_INT_BITS  3'h1

`endif

// ===== common/pwg_pkg.sv
// Types shared by the port wake and interrupt gate
package pwg_pkg;

   // Detection inputs of one port, all one-cycle pulses except the levels
   typedef struct packed
   {
      logic        magic_seen;
      logic [47:0] dest_addr;
      logic        link_up;
      logic        energy;
      logic        ts_irq;
      logic        phy_irq;
      logic        acl_irq;
   } pwg_det_t;

   typedef logic [2:0] pwg_field_t;

   typedef logic [6:0] pwg_port_vec_t;

endpackage

// ===== core/pwg_top.sv
// Per-port wake-event and interrupt gating with an AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "pwg_consts.svh"

// Behaviour
// RULE1: Magic packet drives wake pin only while magic wake enable bit 2 set.
// RULE2: Magic packet counts only if destination equals the switch MAC address.
// RULE3: Link up drives wake pin only while link wake enable bit 1 set.
// RULE4: Cable energy drives wake pin only while energy enable bit 0 set.
// RULE5: Link and energy wake sources exist only on ports with a PHY.
// RULE6: Pending bit 2 shows timestamp interrupt summary, PHY ports only.
// RULE7: Pending bit 1 shows PHY interrupt summary, PHY ports only.
// RULE8: Pending bit 0 set by filter table counter interrupt on every port.
// RULE9: Filter interrupt pending clears only when software toggles its block bit.
// RULE10: Pending bits read-only, reset 0, one while pending; bits 7:3 zero.
// RULE11: Block bits active low enables, reset 0 so every source enabled.
// RULE12: Filter block bit on all ports; timestamp and PHY bits PHY only.
// RULE13: Each wake detection latches a flag that software clears by writing.
// RULE14: Port request high while any pending bit has its block bit clear.
module pwg_top
(
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   input  wire logic                        HSEL,
   input  wire logic [31:0]                 HADDR,
   input  wire logic [1:0]                  HTRANS,
   input  wire logic                        HWRITE,
   input  wire logic [2:0]                  HSIZE,
   input  wire logic [31:0]                 HWDATA,
   input  wire logic                        HREADY,
   output logic      [31:0]                 HRDATA,
   output logic                             HREADYOUT,
   output logic                             HRESP,
   input  wire logic [47:0]                 SWITCH_MAC,
   input  wire pwg_pkg::pwg_det_t [6:0]     DETECT,
   output logic                             WAKE_EVENT_PIN,
   output pwg_pkg::pwg_port_vec_t           PORT_INT_REQ,
   output logic                             IRQ
);
   import pwg_pkg::*;

   // Port 1..7 sit at index 0..6; the first ones carry a PHY
   function automatic logic is_phy(input int p);
      is_phy = (p < `PWG_NPHY);
   endfunction

   // Bits that exist in a per-port field
   function automatic pwg_field_t field_bits(input int p, input logic intr);
      if (is_phy(p))
         field_bits = `PWG_PHY_BITS;
      else if (intr)
         field_bits = `PWG_MAC_INT_BITS;
      else
         field_bits = `PWG_MAC_BITS;
   endfunction

   // Bus data phase state
   logic                    ph_valid_ff;
   logic                    ph_write_ff;
   logic [`PWG_IDX_W-1:0]   ph_idx_ff;
   logic                    rd_done_ff;
   logic [31:0]             hrdata_ff;
   logic                    nxt_ph_valid;
   logic                    nxt_ph_write;
   logic [`PWG_IDX_W-1:0]   nxt_ph_idx;

   // Global event status and mask
   pwg_port_vec_t           irq_stat_ff;
   pwg_port_vec_t           irq_mask_ff;
   pwg_port_vec_t           nxt_irq_stat;
   pwg_port_vec_t           nxt_irq_mask;

   // Per-port registers
   pwg_field_t              enable_ff  [7];
   pwg_field_t              event_ff   [7];
   pwg_field_t              block_ff   [7];
   logic                    acl_ff     [7];
   pwg_field_t              nxt_enable [7];
   pwg_field_t              nxt_event  [7];
   pwg_field_t              nxt_block  [7];
   logic                    nxt_acl    [7];

   pwg_field_t              pending    [7];
   pwg_field_t              det_now    [7];
   logic [31:0]             port_word  [7];
   pwg_port_vec_t           wake_vec;
   pwg_port_vec_t           det_any;

   // Address and strobe decode
   wire                     accept;
   wire                     rd_load;
   wire                     wr_en;
   wire [3:0]               ph_port;
   wire [11:0]              ph_reg;
   wire                     ph_global;
   wire                     wr_irq_stat_rd;
   wire                     wr_irq_mask;
   wire [3:0]               ph_pidx;
   logic [31:0]             rd_word;

   assign accept    = HSEL & HREADY & HTRANS[1];
   assign rd_load   = ph_valid_ff & ~ph_write_ff & ~rd_done_ff;
   assign wr_en     = ph_valid_ff & ph_write_ff;
   assign ph_port   = ph_idx_ff[15:12];
   assign ph_reg    = ph_idx_ff[11:0];
   assign ph_global = (ph_port == `PWG_GLOBAL_PORT);
   assign ph_pidx   = ph_port - 4'h1;
   assign wr_irq_mask = wr_en & ph_global & (ph_reg == `PWG_IDX_IRQ_MASK);
   assign wr_irq_stat_rd = rd_load & ph_global
                           & (ph_reg == `PWG_IDX_IRQ_STAT);

   // Zero-wait writes, one wait state on reads, always OKAY
   assign HREADYOUT = ~rd_load;
   assign HRESP     = 1'b0;
   assign HRDATA    = hrdata_ff;

   assign nxt_ph_valid = HREADY ? accept : ph_valid_ff;
   assign nxt_ph_write = HREADY ? HWRITE : ph_write_ff;
   assign nxt_ph_idx   = HREADY ? HADDR[17:2] : ph_idx_ff;

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ph_valid_ff <= 1'b0;
         ph_write_ff <= 1'b0;
         ph_idx_ff   <= '0;
         rd_done_ff  <= 1'b0;
         hrdata_ff   <= 32'h0;
      end
      else
      begin
         ph_valid_ff <= nxt_ph_valid;
         ph_write_ff <= nxt_ph_write;
         ph_idx_ff   <= nxt_ph_idx;
         rd_done_ff  <= rd_load;
         if (rd_load)
            hrdata_ff <= rd_word;
      end
   end

   genvar p;
   generate
      for (p = 0; p < `PWG_NPORTS; p++)
      begin : g_port
         wire        hit;
         wire        wr_event;
         wire        wr_enable;
         wire        wr_block;
         wire        magic_hit;
         wire        acl_clear;
         pwg_field_t wdat;

         assign hit       = wr_en & ~ph_global & (ph_pidx == 4'(p));
         assign wr_event  = hit & (ph_reg == `PWG_IDX_EVENT);
         assign wr_enable = hit & (ph_reg == `PWG_IDX_ENABLE);
         assign wr_block  = hit & (ph_reg == `PWG_IDX_BLOCK);
         assign wdat      = HWDATA[2:0];

         // Destination must match the switch address
         assign magic_hit = DETECT[p].magic_seen
                            & (DETECT[p].dest_addr == SWITCH_MAC); // [RULE2]

         // Link and energy only on ports with a PHY
         assign det_now[p][`PWG_BIT_MAGIC]  = magic_hit;
         assign det_now[p][`PWG_BIT_LINK]   = DETECT[p].link_up
                                              & is_phy(p); // [RULE5]
         assign det_now[p][`PWG_BIT_ENERGY] = DETECT[p].energy
                                              & is_phy(p); // [RULE5]
         assign det_any[p] = |det_now[p];

         // Latched detection flags, write one clears, set wins
         assign nxt_event[p] = (event_ff[p] & ~(wr_event ? wdat : 3'h0))
                               | det_now[p]; // [RULE13]

         assign nxt_enable[p] = wr_enable ? (wdat & field_bits(p, 1'b0))
                                          : enable_ff[p];

         // Active-low block bits, filter bit on every port
         assign nxt_block[p] = wr_block ? (wdat & field_bits(p, 1'b1))
                                        : block_ff[p]; // [RULE11] [RULE12]

         // Filter pending cleared by a toggle of its block bit
         assign acl_clear = wr_block
                            & (wdat[`PWG_BIT_ACL]
                               != block_ff[p][`PWG_BIT_ACL]); // [RULE9]
         assign nxt_acl[p] = DETECT[p].acl_irq
                             | (acl_ff[p] & ~acl_clear); // [RULE8] [RULE9]

         // Timestamp and PHY summaries on PHY ports only
         assign pending[p][`PWG_BIT_TS]  = DETECT[p].ts_irq
                                           & is_phy(p); // [RULE6]
         assign pending[p][`PWG_BIT_PHY] = DETECT[p].phy_irq
                                           & is_phy(p); // [RULE7]
         assign pending[p][`PWG_BIT_ACL] = acl_ff[p]; // [RULE8]

         // Each enabled latched source holds the wake pin
         assign wake_vec[p] =
            |(event_ff[p] & enable_ff[p]); // [RULE1] [RULE3] [RULE4]

         // Request toward aggregation
         assign PORT_INT_REQ[p] = |(pending[p] & ~block_ff[p]); // [RULE14]

         always_comb
         begin
            port_word[p] = 32'h0;
            case (ph_reg)
               `PWG_IDX_EVENT:   port_word[p][2:0] = event_ff[p];
               `PWG_IDX_ENABLE:  port_word[p][2:0] = enable_ff[p];
               `PWG_IDX_PENDING: port_word[p][2:0] = pending[p]; // [RULE10]
               `PWG_IDX_BLOCK:   port_word[p][2:0] = block_ff[p];
               default:          port_word[p] = 32'h0;
            endcase
         end

         always_ff @(posedge REF_CLK)
         begin
            if (RST)
            begin
               enable_ff[p] <= `PWG_FIELD_RST;
               event_ff[p]  <= `PWG_FIELD_RST;
               block_ff[p]  <= `PWG_FIELD_RST; // [RULE11]
               acl_ff[p]    <= 1'b0; // [RULE10]
            end
            else
            begin
               enable_ff[p] <= nxt_enable[p];
               event_ff[p]  <= nxt_event[p];
               block_ff[p]  <= nxt_block[p];
               acl_ff[p]    <= nxt_acl[p];
            end
         end
      end
   endgenerate

   // Read selection over global and per-port registers
   always_comb
   begin
      rd_word = 32'h0;
      if (ph_global)
      begin
         if (ph_reg == `PWG_IDX_IRQ_STAT)
            rd_word[6:0] = irq_stat_ff;
         else if (ph_reg == `PWG_IDX_IRQ_MASK)
            rd_word[6:0] = irq_mask_ff;
         else
            rd_word = 32'h0;
      end
      else if (ph_pidx < 4'(`PWG_NPORTS))
         rd_word = port_word[ph_pidx[2:0]];
      else
         rd_word = 32'h0;
   end

   // Sticky wake-detection status, cleared by its read, set wins
   assign nxt_irq_stat = (wr_irq_stat_rd ? 7'h00 : irq_stat_ff) | det_any;
   assign nxt_irq_mask = wr_irq_mask ? HWDATA[6:0] : irq_mask_ff;

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         irq_stat_ff <= `PWG_IRQ_RST;
         irq_mask_ff <= `PWG_IRQ_RST;
      end
      else
      begin
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
      end
   end

   assign IRQ            = |(irq_stat_ff & irq_mask_ff);
   assign WAKE_EVENT_PIN = |wake_vec; // [RULE1] [RULE3] [RULE4]

endmodule

// ===== test/pwg_top_sva.sv
// Bus and interrupt checks for the port wake gate
`timescale 1ns/100ps
module pwg_sva
(
   input wire logic                    REF_CLK,
   input wire logic                    RST,
   input wire logic                    HSEL,
   input wire logic [1:0]              HTRANS,
   input wire logic                    HWRITE,
   input wire logic                    HREADY,
   input wire logic [31:0]             HRDATA,
   input wire logic                    HREADYOUT,
   input wire logic                    HRESP,
   input wire pwg_pkg::pwg_det_t [6:0] DETECT,
   input wire logic                    WAKE_EVENT_PIN,
   input wire pwg_pkg::pwg_port_vec_t  PORT_INT_REQ,
   input wire logic                    IRQ
);
   import pwg_pkg::*;
   logic take;
   logic wr_ff;
   logic any_det;
   assign take = HSEL & HREADY & HTRANS[1];
   always_comb
   begin
      any_det = 1'b0;
      for (int i = 0; i < 7; i++)
         any_det = any_det | DETECT[i].magic_seen | DETECT[i].link_up
                   | DETECT[i].energy;
   end
   always_ff @(posedge REF_CLK)
      wr_ff <= !RST & take & HWRITE;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   a_resp_okay: assert property (!HRESP) else $error("resp not okay");
   a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait wrong");
   a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
      else $error("write stalled");
   a_reset_clear: assert property ($past(RST) |-> !IRQ && !WAKE_EVENT_PIN
      && HRDATA == 32'h0) else $error("outputs not clear after reset");
   a_rdata_hold: assert property (!$stable(HRDATA) |-> $past(!HREADYOUT))
      else $error("read data changed");
   a_wake_cause: assert property ($rose(WAKE_EVENT_PIN) |-> $past(any_det)
      || $past(wr_ff)) else $error("wake without cause");
   a_irq_cause: assert property ($rose(IRQ) |-> $past(any_det) || $past(wr_ff))
      else $error("irq without cause");
   a_mac_req_cause: assert property ($rose(PORT_INT_REQ[6]) |->
      $past(DETECT[6].acl_irq) || $past(wr_ff)) else $error("mac req");
   c_read: cover property (take && !HWRITE);
   c_wake: cover property ($rose(WAKE_EVENT_PIN));
   c_irq: cover property ($rose(IRQ));
endmodule
bind pwg_top pwg_sva i_sva (.REF_CLK, .RST, .HSEL, .HTRANS, .HWRITE,
   .HREADY, .HRDATA, .HREADYOUT, .HRESP, .DETECT, .WAKE_EVENT_PIN,
   .PORT_INT_REQ, .IRQ);

// ===== test/pwg_top_tb.sv
// Self-checking bench for the port wake gate
`timescale 1ns/100ps
`include "pwg_consts.svh"
module pwg_top_tb;
   import pwg_pkg::*;
   localparam logic [47:0] MAC = 48'h0a1b2c3d4e5f;
   localparam logic [11:0] EVT = `PWG_IDX_EVENT;
   localparam logic [11:0] ENA = `PWG_IDX_ENABLE;
   localparam logic [11:0] PND = `PWG_IDX_PENDING;
   localparam logic [11:0] BLK = `PWG_IDX_BLOCK;
   localparam pwg_det_t MAGIC = '{magic_seen:1'b1, dest_addr:MAC, default:'0};
   localparam pwg_det_t LINK = '{link_up:1'b1, default:'0};
   localparam pwg_det_t NRG = '{energy:1'b1, default:'0};
   localparam pwg_det_t ACCESS_FILTER_TABLE = '{acl_irq:1'b1, default:'0};
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic [31:0]    haddr = '0;
   logic [1:0]     htrans = '0;
   logic           hwrite = 1'b0;
   logic [31:0]    hwdata = '0;
   logic [31:0]    hrdata;
   logic           hrdyo;
   logic           wake;
   logic           irq;
   pwg_port_vec_t  req;
   pwg_det_t [6:0] det = '0;
   int             miscompares = 0;
   int             n_compared = 0;
   always #20 clk = ~clk;
   pwg_top i_dut (.REF_CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hrdyo), .HRDATA(hrdata), .HREADYOUT(hrdyo), .HRESP(),
      .SWITCH_MAC(MAC), .DETECT(det), .WAKE_EVENT_PIN(wake),
      .PORT_INT_REQ(req), .IRQ(irq));
   task automatic wrap_up;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic hwait;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hrdyo !== 1'b1 && n < 20);
      if (hrdyo !== 1'b1)
      begin
         miscompares++;
         wrap_up;
      end
   endtask
   task automatic bus(input logic w, logic [15:0] i, logic [31:0] d,
                      output logic [31:0] r);
      htrans <= 2'h2;
      haddr <= {14'h0, i, 2'h0};
      hwrite <= w;
      hwait;
      htrans <= 2'h0;
      hwdata <= d;
      hwait;
      r = hrdata;
   endtask
   task automatic wr(input logic [15:0] i, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, i, d, r);
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] i, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, i, 32'h0, r);
      chk($sformatf("reg %h", i), e, r);
   endtask
   task automatic pulse(input int p, input pwg_det_t v);
      det[p] <= v;
      @(posedge clk);
      det[p] <= '0;
      @(posedge clk);
   endtask
   task automatic t_reset;
      rd({4'h1, ENA}, 32'h0);
      rd({4'h1, PND}, 32'h0);
      rd({4'h7, BLK}, 32'h0);
      rd({4'h1, 12'h020}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_magic;
      wr({4'h1, ENA}, 32'h4);
      pulse(0, '{magic_seen:1'b1, dest_addr:~MAC, default:'0});
      chk("wake", 32'h0, 32'(wake));
      pulse(0, MAGIC);
      chk("wake", 32'h1, 32'(wake));
      rd({4'h1, EVT}, 32'h4);
      wr({4'h1, EVT}, 32'h4);
      chk("wake", 32'h0, 32'(wake));
      wr({4'h1, ENA}, 32'h0);
      pulse(0, MAGIC);
      chk("wake", 32'h0, 32'(wake));
      wr({4'h1, EVT}, 32'h4);
      $display("test magic done");
   endtask
   task automatic t_phy;
      wr({4'h2, ENA}, 32'h3);
      pulse(1, LINK);
      chk("wake", 32'h1, 32'(wake));
      rd({4'h2, EVT}, 32'h2);
      wr({4'h2, EVT}, 32'h2);
      pulse(1, NRG);
      chk("wake", 32'h1, 32'(wake));
      wr({4'h2, EVT}, 32'h1);
      wr({4'h2, ENA}, 32'h0);
      wr({4'h6, ENA}, 32'h7);
      rd({4'h6, ENA}, 32'h4);
      pulse(5, LINK);
      pulse(5, NRG);
      chk("wake", 32'h0, 32'(wake));
      rd({4'h6, EVT}, 32'h0);
      wr({4'h6, ENA}, 32'h0);
      $display("test phy wake done");
   endtask
   task automatic t_acl;
      pulse(6, ACCESS_FILTER_TABLE);
      rd({4'h7, PND}, 32'h1);
      chk("req", 32'h40, 32'(req));
      wr({4'h7, BLK}, 32'h7);
      rd({4'h7, BLK}, 32'h1);
      rd({4'h7, PND}, 32'h0);
      pulse(6, ACCESS_FILTER_TABLE);
      chk("req", 32'h0, 32'(req));
      wr({4'h7, BLK}, 32'h0);
      rd({4'h7, PND}, 32'h0);
      $display("test filter done");
   endtask
   task automatic t_live;
      det[0] <= '{ts_irq:1'b1, phy_irq:1'b1, default:'0};
      det[5] <= '{ts_irq:1'b1, phy_irq:1'b1, default:'0};
      rd({4'h1, PND}, 32'h6);
      rd({4'h6, PND}, 32'h0);
      chk("req", 32'h1, 32'(req));
      wr({4'h1, BLK}, 32'h6);
      chk("req", 32'h0, 32'(req));
      wr({4'h1, BLK}, 32'h2);
      chk("req", 32'h1, 32'(req));
      wr({4'h1, BLK}, 32'h0);
      det <= '0;
      $display("test live done");
   endtask
   task automatic t_irq;
      // Ports 1 and 2 saw wake detections in earlier tests
      rd({4'h0, `PWG_IDX_IRQ_STAT}, 32'h3);
      rd({4'h0, `PWG_IDX_IRQ_STAT}, 32'h0);
      wr({4'h0, `PWG_IDX_IRQ_MASK}, 32'h1);
      pulse(0, NRG);
      chk("irq", 32'h1, 32'(irq));
      rd({4'h0, `PWG_IDX_IRQ_STAT}, 32'h1);
      chk("irq", 32'h0, 32'(irq));
      pulse(1, LINK);
      chk("irq", 32'h0, 32'(irq));
      rd({4'h0, `PWG_IDX_IRQ_STAT}, 32'h2);
      $display("test irq done");
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_magic;
      t_phy;
      t_acl;
      t_live;
      t_irq;
      wrap_up;
   end
endmodule
